/* logic/btbc_params.svh */
// constants for the bit toggle, branch and call executor
`ifndef BTBC_PARAMS_SVH
`define BTBC_PARAMS_SVH

`define BTBC_OPC_TOGGLE 4'h7
`define BTBC_OPC_BR_OV 8'hE4
`define BTBC_OPC_BR_Z 8'hE0
`define BTBC_OPC_CALL 7'h76
`define BTBC_OPC_CALL2 4'hF
`define BTBC_FLAG_Z 2
`define BTBC_FLAG_OV 3
`define BTBC_IDX_LIMIT 8'h5F
`define BTBC_ACC_HIGH_BANK 4'hF
`define BTBC_ACC_LOW_BANK 4'h0
`define BTBC_PC_STEP 21'h000002
`define BTBC_CALL_STEP 21'h000004
`define BTBC_REG_CTRL 8'h00
`define BTBC_REG_IDX_BASE 8'h04
`define BTBC_REG_SHADOW 8'h08
`define BTBC_REG_STATE 8'h0C
`define BTBC_CTRL_RESET 1'h0
`define BTBC_IDX_RESET 12'h000

`endif

/* logic/btbc_pkg.sv */
// types for the bit toggle, branch and call executor
package btbc_pkg;

    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } btbc_phase_type;

    typedef enum logic [1:0] {
        CY_EXEC = 2'b01,
        CY_NOP = 2'b10
    } btbc_cycle_type;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00001,
        OP_TOGGLE = 5'b00010,
        OP_BR_OV = 5'b00100,
        OP_BR_Z = 5'b01000,
        OP_CALL = 5'b10000
    } btbc_op_type;

    typedef struct packed {
        logic rd;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } btbc_dmem_type;

    typedef struct packed {
        logic valid;
        logic [20:0] data;
    } btbc_push_type;

    typedef struct packed {
        logic load;
        logic [20:0] target;
    } btbc_pc_type;

    typedef struct packed {
        btbc_phase_type phase;
        btbc_cycle_type cyc;
        btbc_op_type op;
        btbc_op_type last_op;
        logic last_taken;
        logic [15:0] ir;
        logic [20:0] pc;
        logic [7:0] rdata;
        btbc_pc_type pcw;
        btbc_push_type push;
        btbc_dmem_type dmem;
        logic [7:0] working_shadow;
        logic [7:0] flags_shadow;
        logic [3:0] bank_select_shadow;
        logic ext_en;
        logic [11:0] idx_base;
        logic wb_ack;
        logic [31:0] wb_dat;
    } btbc_state_type;

endpackage : btbc_pkg

/* logic/btbc_exec.sv */
// executor for bit toggle, conditional branches and call
`timescale 1ns/10ps
`include "btbc_params.svh"

module btbc_exec
    import btbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic [15:0] prefetch_i,
    input wire logic [20:0] pc_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] w_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [7:0] dmem_rdata_i,
    output btbc_dmem_type dmem_o,
    output btbc_pc_type pc_o,
    output btbc_push_type stack_top_o,
    output logic nop_o,
    output btbc_phase_type phase_o,
    output logic [7:0] working_shadow_o,
    output logic [7:0] flags_shadow_o,
    output logic [3:0] bank_select_shadow_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ==========================================
    // helper functions
    function automatic btbc_op_type decode_op(input logic [15:0] word);
        btbc_op_type op;
        op = OP_NONE;
        if (word[15:12] == `BTBC_OPC_TOGGLE) begin
            op = OP_TOGGLE;
        end else if (word[15:8] == `BTBC_OPC_BR_OV) begin
            op = OP_BR_OV;
        end else if (word[15:8] == `BTBC_OPC_BR_Z) begin
            op = OP_BR_Z;
        end else if (word[15:9] == `BTBC_OPC_CALL) begin
            op = OP_CALL;
        end
        return op;
    endfunction : decode_op

    function automatic logic [11:0] resolve_addr(
        input logic [7:0] f,
        input logic a,
        input logic [3:0] bank,
        input logic ext,
        input logic [11:0] base
    );
        logic [11:0] addr;
        addr = {`BTBC_ACC_LOW_BANK, f};
        if (a) begin
            addr = {bank, f};
        end else if (ext && (f <= `BTBC_IDX_LIMIT)) begin
            addr = base + {4'h0, f};
        end else if (f > `BTBC_IDX_LIMIT) begin
            addr = {`BTBC_ACC_HIGH_BANK, f};
        end
        return addr;
    endfunction : resolve_addr

    function automatic logic [20:0] branch_target(
        input logic [20:0] pc,
        input logic [7:0] n
    );
        logic [20:0] disp;
        disp = {{12{n[7]}}, n, 1'b0};
        return pc + `BTBC_PC_STEP + disp;
    endfunction : branch_target

    function automatic logic [7:0] merge_lane(
        input logic [7:0] old,
        input logic [7:0] new_val,
        input logic en
    );
        return en ? new_val : old;
    endfunction : merge_lane

    // ==========================================
    // state
    btbc_state_type q;
    btbc_state_type d;
    logic wb_req;
    logic wb_take;
    logic taken;
    logic [7:0] bit_mask;

    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_take = wb_req && q.wb_ack;

    // ==========================================
    // next state
    always_comb begin
        d = q;
        d.dmem.rd = 1'b0;
        d.dmem.we = 1'b0;
        d.pcw.load = 1'b0;
        d.push.valid = 1'b0;
        taken = 1'b0;
        bit_mask = 8'h01 << q.ir[11:9];

        case (q.phase)
            PH_Q1: begin
                d.phase = PH_Q2;
            end
            PH_Q2: begin
                d.phase = PH_Q3;
            end
            PH_Q3: begin
                d.phase = PH_Q4;
            end
            PH_Q4: begin
                d.phase = PH_Q1;
            end
            default: begin
                d.phase = PH_Q1;
            end
        endcase

        if (q.cyc == CY_EXEC) begin
            case (q.phase)
                PH_Q1: begin
                    d.ir = instr_i;
                    d.pc = pc_i;
                    d.op = decode_op(instr_i);
                    if (decode_op(instr_i) == OP_TOGGLE) begin
                        d.dmem.rd = 1'b1;
                        d.dmem.addr = resolve_addr(instr_i[7:0], instr_i[8],
                            bank_select_reg_i, q.ext_en, q.idx_base);
                    end
                end
                PH_Q2: begin
                    if (q.op == OP_TOGGLE) begin
                        d.rdata = dmem_rdata_i;
                    end
                    if (q.op == OP_CALL) begin
                        d.push.valid = 1'b1;
                        d.push.data = q.pc + `BTBC_CALL_STEP;
                        if (q.ir[8]) begin
                            d.working_shadow = w_i;
                            d.flags_shadow = status_i;
                            d.bank_select_shadow = bank_select_reg_i;
                        end
                    end
                end
                PH_Q3: begin
                    case (q.op)
                        OP_TOGGLE: begin
                            d.dmem.we = 1'b1;
                            d.dmem.wdata = q.rdata ^ bit_mask;
                        end
                        OP_BR_OV: begin
                            taken = status_i[`BTBC_FLAG_OV];
                        end
                        OP_BR_Z: begin
                            taken = status_i[`BTBC_FLAG_Z];
                        end
                        OP_CALL: begin
                            d.pcw.load = 1'b1;
                            d.pcw.target = {prefetch_i[11:0], q.ir[7:0], 1'b0};
                        end
                        default: begin
                            taken = 1'b0;
                        end
                    endcase
                    if (taken) begin
                        d.pcw.load = 1'b1;
                        d.pcw.target = branch_target(q.pc, q.ir[7:0]);
                    end
                end
                PH_Q4: begin
                    d.last_op = q.op;
                    d.last_taken = q.pcw.load;
                    if (q.pcw.load) begin
                        d.cyc = CY_NOP;
                    end
                    d.op = OP_NONE;
                end
                default: begin
                    d.op = OP_NONE;
                end
            endcase
        end else if (q.phase == PH_Q4) begin
            d.cyc = CY_EXEC;
        end

        // ==========================================
        // register bus
        d.wb_ack = wb_req && !q.wb_ack;
        if (wb_req && !q.wb_ack) begin
            case (wb_adr_i)
                `BTBC_REG_CTRL: begin
                    d.wb_dat = {31'h00000000, q.ext_en};
                end
                `BTBC_REG_IDX_BASE: begin
                    d.wb_dat = {20'h00000, q.idx_base};
                end
                `BTBC_REG_SHADOW: begin
                    d.wb_dat = {4'h0, q.bank_select_shadow, 4'h0, 4'h0,
                        q.flags_shadow, q.working_shadow};
                end
                `BTBC_REG_STATE: begin
                    d.wb_dat = {15'h0000, q.last_taken, q.last_op,
                        q.cyc, q.op, q.phase};
                end
                default: begin
                    d.wb_dat = 32'h00000000;
                end
            endcase
        end
        if (wb_take && wb_we_i) begin
            case (wb_adr_i)
                `BTBC_REG_CTRL: begin
                    if (wb_sel_i[0]) begin
                        d.ext_en = wb_dat_i[0];
                    end
                end
                `BTBC_REG_IDX_BASE: begin
                    d.idx_base[7:0] = merge_lane(q.idx_base[7:0], wb_dat_i[7:0], wb_sel_i[0]);
                    if (wb_sel_i[1]) begin
                        d.idx_base[11:8] = wb_dat_i[11:8];
                    end
                end
                default: begin
                    d.ext_en = d.ext_en;
                end
            endcase
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.phase <= PH_Q1;
            q.cyc <= CY_EXEC;
            q.op <= OP_NONE;
            q.last_op <= OP_NONE;
            q.last_taken <= 1'b0;
            q.ir <= 16'h0000;
            q.pc <= 21'h000000;
            q.rdata <= 8'h00;
            q.pcw <= '0;
            q.push <= '0;
            q.dmem <= '0;
            q.working_shadow <= 8'h00;
            q.flags_shadow <= 8'h00;
            q.bank_select_shadow <= 4'h0;
            q.ext_en <= `BTBC_CTRL_RESET;
            q.idx_base <= `BTBC_IDX_RESET;
            q.wb_ack <= 1'b0;
            q.wb_dat <= 32'h00000000;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // outputs
    assign dmem_o = q.dmem;
    assign pc_o = q.pcw;
    assign stack_top_o = q.push;
    assign nop_o = (q.cyc == CY_NOP);
    assign phase_o = q.phase;
    assign working_shadow_o = q.working_shadow;
    assign flags_shadow_o = q.flags_shadow;
    assign bank_select_shadow_o = q.bank_select_shadow;
    assign wb_dat_o = q.wb_dat;
    assign wb_ack_o = q.wb_ack;

endmodule : btbc_exec

/* test/btbc_dmem_model.sv */
// data memory model facing the executor
`timescale 1ns/10ps
module btbc_dmem_model
    import btbc_pkg::*;
(
    input wire logic clk_i,
    input btbc_dmem_type dmem_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:4095];
    initial begin
        for (int a = 0; a < 4096; a++) begin
            mem[a] = a[7:0] ^ 8'h5A;
        end
    end
    // ==========
    // read port, inverted when idle
    assign rdata_o = dmem_i.rd ? mem[dmem_i.addr] : ~mem[dmem_i.addr];
    always @(posedge clk_i) begin
        if (dmem_i.we) begin
            mem[dmem_i.addr] <= dmem_i.wdata;
        end
    end
endmodule : btbc_dmem_model

/* test/btbc_exec_checker.sv */
// assertions on the executor ports
`timescale 1ns/10ps
module btbc_exec_checker
    import btbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic [20:0] pc_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] dmem_rdata_i,
    input btbc_dmem_type dmem_o,
    input btbc_pc_type pc_o,
    input btbc_push_type stack_top_o,
    input wire logic nop_o,
    input btbc_phase_type phase_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // toggle
    // write follows read
    a_toggle_rw: assert property (dmem_o.rd |-> ##2 dmem_o.we && dmem_o.addr == $past(dmem_o.addr, 2))
        else $error("toggle write missing");
    a_one_bit: assert property (dmem_o.we |-> $countones(dmem_o.wdata ^ $past(dmem_rdata_i, 2)) == 1)
        else $error("toggle changed wrong bits");
    a_toggle_only: assert property (dmem_o.we |-> $past(instr_i[15:12], 3) == 4'h7)
        else $error("write without toggle");
    // ==========
    // branches, call and bus ack
    // load in last phase
    a_load_q4: assert property (pc_o.load |-> phase_o == PH_Q4)
        else $error("pc load outside q4");
    a_taken_nop: assert property (pc_o.load |=> nop_o [*4] ##1 !nop_o)
        else $error("nop cycle wrong");
    a_nop_cause: assert property ($rose(nop_o) |-> $past(pc_o.load))
        else $error("nop without load");
    a_zero_flag: assert property (pc_o.load && $past(instr_i[15:8], 3) == 8'hE0 |-> $past(status_i[2]))
        else $error("zero branch taken on clear flag");
    a_ov_flag: assert property (pc_o.load && $past(instr_i[15:8], 3) == 8'hE4 |-> $past(status_i[3]))
        else $error("overflow branch taken on clear flag");
    a_push_load: assert property (stack_top_o.valid |=> pc_o.load)
        else $error("push not followed by load");
    a_push_data: assert property (stack_top_o.valid |-> stack_top_o.data == $past(pc_i, 2) + 21'h000004)
        else $error("return address wrong");
    a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    c_toggle: cover property (dmem_o.we);
    c_branch: cover property (pc_o.load && !$past(stack_top_o.valid));
    c_call: cover property (stack_top_o.valid);
endmodule : btbc_exec_checker
bind btbc_exec btbc_exec_checker chk_u (.clk_i, .rst_i, .instr_i, .pc_i, .status_i, .dmem_rdata_i, .dmem_o,
    .pc_o, .stack_top_o, .nop_o, .phase_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* test/btbc_exec_tb.sv */
// bench for the executor
`timescale 1ns/10ps
module btbc_exec_tb
    import btbc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr_i = 16'h0000, prefetch_i = 16'h0000;
    logic [20:0] pc_i = 21'h000100;
    logic [7:0] status_i = 8'h00, w_i = 8'h00, rdata, ws_o, fs_o, f, op, fb, n;
    logic [3:0] bank_i = 4'h0, wb_sel_i = 4'hF, bs_o;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, nop_o, tk;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd_q, pat;
    logic [11:0] r_wa;
    logic [7:0] r_wd;
    logic [20:0] r_tg, r_pd;
    btbc_dmem_type dmem_o;
    btbc_pc_type pc_o;
    btbc_push_type stack_top_o;
    btbc_phase_type phase_o;
    int errors = 0, total_checks = 0, cycles = 0, r_nop;
    always #2.5 clk_i = ~clk_i;
    btbc_exec dut_u (.clk_i, .rst_i, .instr_i, .prefetch_i, .pc_i, .status_i, .w_i, .bank_select_reg_i(bank_i),
        .dmem_rdata_i(rdata), .dmem_o, .pc_o, .stack_top_o, .nop_o, .phase_o, .working_shadow_o(ws_o),
        .flags_shadow_o(fs_o), .bank_select_shadow_o(bs_o), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    btbc_dmem_model mem_u (.clk_i, .dmem_i(dmem_o), .rdata_o(rdata));
    // ==========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic align();
        do @(negedge clk_i); while (phase_o !== PH_Q4);
        @(posedge clk_i);
    endtask : align
    task automatic step(input logic [15:0] ins, input logic [15:0] pre, input logic [7:0] st);
        instr_i <= ins;
        prefetch_i <= pre;
        status_i <= st;
        r_nop = 0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_i);
            pat = {pat[27:0], dmem_o.rd, stack_top_o.valid, dmem_o.we, pc_o.load};
            r_nop += (i > 3 && nop_o === 1'b1);
            if (i == 2) r_pd = stack_top_o.data;
            if (i == 3) {r_wa, r_wd, r_tg} = {dmem_o.addr, dmem_o.wdata, pc_o.target};
            @(posedge clk_i);
            if (i == 3) instr_i <= 16'h0000;
        end
    endtask : step
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    // ==========
    // scenarios
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bank_i <= 4'h3;
        for (int b = 0; b < 8; b++) begin
            f = 8'h40 + b[7:0];
            step({4'h7, b[2:0], 1'b1, f}, 16'h0000, 8'h00);
            chk(pat, 32'h08020000);
            chk(r_wa, {4'h3, f});
            chk(r_wd, f ^ 8'h5A ^ (8'h01 << b));
        end
        for (int j = 0; j < 3; j++) begin
            f = j < 2 ? 8'h30 : 8'h9C;
            step({8'h70, f}, 16'h0000, 8'h00);
            chk(r_wa, {f > 8'h5F ? 4'hF : 4'h0, f});
            chk(r_wd, f ^ 8'h5A ^ (j == 1 ? 8'h00 : 8'h01));
        end
        wb(1'b1, 8'h00, 32'h00000001);
        wb(1'b1, 8'h04, 32'h00000100);
        wb(1'b0, 8'h04, 32'h00000000);
        chk(rd_q, 32'h00000100);
        wb(1'b0, 8'h20, 32'h00000000);
        chk(rd_q, 32'h00000000);
        align();
        step(16'h705F, 16'h0000, 8'h00);
        chk(r_wa, 12'h15F);
        step(16'h7060, 16'h0000, 8'h00);
        chk(r_wa, 12'hF60);
        step(16'h715F, 16'h0000, 8'h00);
        chk(r_wa, 12'h35F);
        for (int k = 0; k < 12; k++) begin
            op = k[0] ? 8'hE4 : 8'hE0;
            fb = k[0] ? 8'h08 : 8'h04;
            tk = k[1];
            n = k[3:2] == 0 ? 8'h80 : (k[3:2] == 1 ? 8'h7F : 8'h00);
            step({op, n}, 16'h0000, tk ? fb : ~fb);
            chk(pat, tk ? 32'h00010000 : 32'h00000000);
            chk(r_nop, tk ? 4 : 0);
            if (tk) chk(r_tg, 21'(pc_i + 21'h000002 + {{12{n[7]}}, n, 1'b0}));
        end
        w_i <= 8'hC3;
        bank_i <= 4'h9;
        step(16'hED5A, 16'hF7A2, 8'h1B);
        chk(pat, 32'h00410000);
        chk(r_pd, pc_i + 21'h000004);
        chk(r_tg, {12'h7A2, 8'h5A, 1'b0});
        chk(r_nop, 4);
        w_i <= 8'h3C;
        bank_i <= 4'h6;
        step(16'hEC11, 16'hF0FF, 8'h00);
        chk(r_tg, {12'h0FF, 8'h11, 1'b0});
        chk({bs_o, fs_o, ws_o}, {4'h9, 8'h1B, 8'hC3});
        wb(1'b0, 8'h0C, 32'h00000000);
        chk(rd_q, 32'h00018211);
        wb(1'b1, 8'h08, 32'hFFFFFFFF);
        wb(1'b0, 8'h08, 32'h00000000);
        chk(rd_q, 32'h09001BC3);
        summarize();
    end
endmodule : btbc_exec_tb
